/* File: sim/analog_source.sv */
// Purpose: Far-side model, analog reference source and switch contact.
// Assumes: The bench sets the level and the contact; one sample every TICK_GAP cycles.
// Notes: Between strobes the sample bus carries junk, like a converter bus in transit.
`timescale 1ns/100ps
`default_nettype none
module analog_source #(
  parameter int TICK_GAP = 4 // Cycles between samples
) (
  input wire logic ref_clk, // System clock
  input wire logic [13:0] level, // Level to present
  input wire logic pin, // Contact level
  output logic [13:0] analog_input_signal, // Sample bus
  output logic sample_tick, // Sample strobe
  output logic digital_input_signal // Contact line
);
  int cnt = 0; // Strobe spacing
  // Known values at time zero
  initial begin
    sample_tick = 1'b0;
    analog_input_signal = 14'h0;
    digital_input_signal = 1'b1;
  end
  // One-cycle strobe with the level, inverted junk otherwise
  always @(posedge ref_clk) begin
    cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
    sample_tick <= (cnt == 0);
    analog_input_signal <= (cnt == 0) ? level : ~level;
    digital_input_signal <= pin;
  end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench of the analog input conditioning block.
// Assumes: Zero-wait bus, tick every 4 cycles, 4 cycles per ms.
// Notes: Expected values go to a queue; a watcher compares them.
`include "aic_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import aic_pkg::*;
  logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, pin = 1, start_signal = 0, drive_standstill = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, obs, r;
  logic [1:0] htrans = 0;
  logic [13:0] level = 0, analog_input_signal;
  logic hreadyout, hresp, sample_tick, digital_input_signal, warn_out, fault_out, error_out;
  logic ramp_stop_req, coast_req, digital_raw, digital_processed, thermal_contact, p;
  logic signed [15:0] ref_out;
  logic [31:0] exp_q[$]; // Expected results, oldest first
  event obs_ev; // A result is ready
  int n_fail = 0, n_tests = 0, seed = 13;
  analog_input_conditioning #(.CYCLES_PER_MS(4)) analog_input_conditioning_inst (.ref_clk(ref_clk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .analog_input_signal(analog_input_signal), .sample_tick(sample_tick),
    .digital_input_signal(digital_input_signal), .start_signal(start_signal),
    .drive_standstill(drive_standstill), .ref_out(ref_out), .warn_out(warn_out), .fault_out(fault_out),
    .error_out(error_out), .ramp_stop_req(ramp_stop_req), .coast_req(coast_req),
    .digital_raw(digital_raw), .digital_processed(digital_processed), .thermal_contact(thermal_contact));
  analog_source #(.TICK_GAP(4)) analog_source_inst (.ref_clk(ref_clk), .level(level), .pin(pin),
    .analog_input_signal(analog_input_signal), .sample_tick(sample_tick),
    .digital_input_signal(digital_input_signal));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watcher: oldest note against each observed result
  always @(obs_ev) begin
    n_tests++;
    if (exp_q.size() == 0 || obs !== exp_q[0]) begin
      n_fail++;
      $display("FAIL %0t: saw %h", $time, obs);
    end
    if (exp_q.size() > 0) begin
      void'(exp_q.pop_front());
    end
  end
  // Note an expectation, then hand over the observed value
  task automatic expect_val(input logic [31:0] e, input logic [31:0] v);
    exp_q.push_back(e);
    @(negedge ref_clk);
    obs = v;
    -> obs_ev;
  endtask
  // Let samples pass the filter, curve and supervision
  task automatic settle;
    repeat (16) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: bounded wait for hready at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    expect_val(e, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`REG_CTRL, 32'h3);
    rd(`REG_TOL, 32'hc8);
    rd(`REG_X1, 32'hc8);
    rd(`REG_X2, 32'h2648);
    rd(`REG_Y2, 32'h2710);
    rd(32'h40, 32'h0);
    expect_val(32'h0, hresp);
    wr(`REG_TOL, 32'hfff);
    rd(`REG_TOL, 32'h9c4);
    foreach (TAU_CODES[i]) begin
      wr(`REG_TAU, 32'(TAU_CODES[i]));
      wr(`REG_TAU, 32'h3);
      rd(`REG_TAU, 32'(TAU_CODES[i]));
    end
    wr(`REG_TAU, 32'h0);
    $display("Test registers done");
    // Digital: low-active default, raw source on thermal
    pin <= 1'b0;
    settle();
    expect_val(32'h1, digital_raw);
    expect_val(32'h1, thermal_contact);
    wr(`REG_CTRL, 32'h104);
    repeat (4) begin
      p = 1'($random(seed));
      pin <= p;
      settle();
      expect_val(p, digital_raw);
      expect_val(p, digital_processed);
      expect_val(p, thermal_contact);
    end
    $display("Test digital done");
    // Analog, mode 0, then curve and hysteresis
    wr(`REG_CTRL, 32'h6);
    level <= 14'd500;
    settle();
    expect_val(32'h0, warn_out);
    level <= 14'd5000;
    settle();
    expect_val(32'd5000, 32'(ref_out));
    wr(`REG_TOL, 32'd100);
    wr(`REG_MINREF, 32'd500);
    // Bipolar curve from -100 % to +100 %, zero crossing at input 5000
    wr(`REG_Y1, 32'hd8f0);
    level <= 14'd5050;
    settle();
    expect_val(32'd500, 32'(ref_out));
    level <= 14'd4850;
    settle();
    expect_val(32'hfffffe0c, 32'(ref_out));
    level <= 14'd5050;
    settle();
    expect_val(32'hfffffe0c, 32'(ref_out));
    $display("Test curve done");
    // Mode 1: warning only, sticky until cleared
    wr(`REG_CTRL, 32'h16);
    level <= 14'd1000 + 14'($random(seed) & 32'h1fff);
    settle();
    expect_val(32'h0, warn_out);
    level <= 14'd999;
    settle();
    expect_val(32'h1, warn_out);
    expect_val(32'h0, fault_out);
    level <= 14'd5000;
    settle();
    expect_val(32'h1, warn_out);
    wr(`REG_STATUS, 32'h1);
    @(negedge ref_clk);
    expect_val(32'h0, warn_out);
    // Mode 3: coast, then restart
    wr(`REG_CTRL, 32'h36);
    level <= 14'd999;
    settle();
    expect_val(32'h1, coast_req);
    expect_val(32'h1, fault_out);
    expect_val(32'h0, ramp_stop_req);
    level <= 14'd5000;
    start_signal <= 1'b1;
    settle();
    start_signal <= 1'b0;
    settle();
    expect_val(32'h0, coast_req);
    expect_val(32'h0, fault_out);
    // Mode 2: controlled stop, hold 3 ms, error, restart
    wr(`REG_CTRL, 32'h26);
    wr(`REG_HOLD, 32'h3);
    level <= 14'd999;
    settle();
    expect_val(32'h1, ramp_stop_req);
    expect_val(32'h1, fault_out);
    expect_val(32'h0, error_out);
    drive_standstill <= 1'b1;
    settle();
    expect_val(32'h1, error_out);
    level <= 14'd5000;
    drive_standstill <= 1'b0;
    start_signal <= 1'b1;
    settle();
    start_signal <= 1'b0;
    settle();
    expect_val(32'h0, ramp_stop_req);
    expect_val(32'h0, error_out);
    @(posedge ref_clk);
    $display("Test supervision done");
    finish_test();
  end
endmodule
`default_nettype wire

/* File: verilog/aic_pkg.sv */
// Purpose: Types of the analog input conditioning block.
// Assumes: Nothing beyond the constants header.
// Notes: Shared by the top module and the filter.
`default_nettype none
package aic_pkg;
  // Supervision sequence states
  typedef enum logic [2:0] {
    MON_RUN = 3'h0,
    MON_STOPPING = 3'h1,
    MON_HOLDING = 3'h2,
    MON_ERROR = 3'h3,
    MON_COASTING = 3'h4
  } mon_state_type;
  // Legal filter time constants in ms
  typedef logic [12:0] tau_type;
  localparam tau_type TAU_CODES [15] = '{13'h0, 13'h2, 13'h4, 13'h8, 13'h10, 13'h20, 13'h40, 13'h80,
    13'h100, 13'h200, 13'h3e8, 13'h7d0, 13'hbb8, 13'hfa0, 13'h1388};
endpackage
`default_nettype wire

/* File: verilog/aic_regs.svh */
// Purpose: Constants of the analog input conditioning block.
// Assumes: Analog samples in 0.01 % of full scale, 10000 = 10 V or 20 mA.
// Notes: Byte offsets on a 32-bit AHB-Lite register bus.
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_TOL 8'h04
`define REG_TAU 8'h08
`define REG_X1 8'h0c
`define REG_Y1 8'h10
`define REG_X2 8'h14
`define REG_Y2 8'h18
`define REG_MINREF 8'h1c
`define REG_HOLD 8'h20
`define REG_STATUS 8'h24
`define REG_FILT 8'h28
`define REG_REF 8'h2c

// Control fields and codes
`define CTRL_INMODE 2:0
`define CTRL_MON 5:4
`define CTRL_THERM 8
`define INMODE_NPN 3'h3
`define INMODE_PNP 3'h4
`define INMODE_VOLT 3'h6
`define INMODE_CURR 3'h7
`define MON_OFF 2'h0
`define MON_WARN 2'h1
`define MON_RAMP 2'h2
`define MON_COAST 2'h3

// Status bits
`define ST_WARN 0
`define ST_FAULT 1
`define ST_ERROR 2

// Reset values, in 0.01 %; hold and time constant in ms
`define TOL_RESET 12'h0c8
`define TOL_MAX 12'h9c4
`define X1_RESET 14'h00c8
`define X2_RESET 14'h2648
`define Y1_RESET 16'h0000
`define Y2_RESET 16'h2710
`define MINREF_RESET 14'h0000
`define HOLD_RESET 16'h0000
`define TAU_RESET 13'h0000

// Floor: 1 V of 10 V and 2 mA of 20 mA are both 10 % of full scale
`define FLOOR_LEVEL 14'h03e8
`define REF_LIMIT 34'sh0000_2710

// Timing
`define CLK_PERIOD_NS 4
`define HOLD_UNIT_NS 1000000
`define SAMPLE_PERIOD_US 1000
`define ALPHA_FULL 17'h10000
`define ALPHA(t) (17'((64'd65536 * `SAMPLE_PERIOD_US) / ((t) * 1000)))

`endif

/* File: verilog/analog_input_conditioning.sv */
// Purpose: Conditions the second multifunction input, analog or digital.
// Assumes: Samples arrive with sample_tick, 0.01 % steps of full scale.
// Notes: Registers on AHB-Lite, zero wait states, always OKAY.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`include "aic_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module analog_input_conditioning
  import aic_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `HOLD_UNIT_NS / `CLK_PERIOD_NS // Clock cycles per ms
) (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic reset, // Asynchronous reset, high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic [13:0] analog_input_signal, // Sample, 0.01 % steps
  input wire logic sample_tick, // New sample strobe
  input wire logic digital_input_signal, // Pin level, high is 24 V
  input wire logic start_signal, // Operator start command
  input wire logic drive_standstill, // Drive has stopped
  output logic signed [15:0] ref_out, // Reference, 0.01 % steps
  output logic warn_out, // Floor warning
  output logic fault_out, // Floor fault
  output logic error_out, // Error after holding time
  output logic ramp_stop_req, // Controlled stop request
  output logic coast_req, // Coast request
  output logic digital_raw, // Evaluated input, hardware source
  output logic digital_processed, // Evaluated input, processed source
  output logic thermal_contact // Thermal contact function
);
  ////////////////////////////////////////////////////////////
  // Declarations
  logic wr_pend_q, wr_pend_d; // Write data phase pending
  logic [7:0] wr_addr_q, wr_addr_d; // Write address
  logic [31:0] rdata_q, rdata_d; // Read data
  logic [2:0] in_mode_q, in_mode_d; // Input mode code
  logic [1:0] mon_mode_q, mon_mode_d; // Monitoring mode
  logic therm_sel_q, therm_sel_d; // Thermal source, 1 is processed
  logic [11:0] tol_q, tol_d; // Tolerance band
  tau_type tau_q, tau_d; // Time constant code
  logic [16:0] alpha_q, alpha_d; // Filter coefficient
  logic [13:0] x1_q, x1_d, x2_q, x2_d; // Curve inputs
  logic signed [15:0] y1_q, y1_d, y2_q, y2_d; // Curve outputs
  logic [13:0] minref_q, minref_d; // Minimum magnitude
  logic [15:0] hold_q, hold_d; // Holding time in ms
  mon_state_type mon_q, mon_d; // Supervision state, read back in status
  logic addr_ok, clr_warn, clr_fault, clr_error; // Decode and acknowledges
  filt_if fbus (); // Filter link

  ////////////////////////////////////////////////////////////
  // Bus slave and register file
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign clr_warn = wr_pend_q && wr_addr_q == `REG_STATUS && hwdata[`ST_WARN];
  assign clr_fault = wr_pend_q && wr_addr_q == `REG_STATUS && hwdata[`ST_FAULT];
  assign clr_error = wr_pend_q && wr_addr_q == `REG_STATUS && hwdata[`ST_ERROR];

  // Next values of bus and register state
  always_comb begin
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = haddr[31:8] == 24'h0 ? haddr[7:0] : 8'hff;
    rdata_d = rdata_q;
    in_mode_d = in_mode_q;
    mon_mode_d = mon_mode_q;
    therm_sel_d = therm_sel_q;
    tol_d = tol_q;
    tau_d = tau_q;
    alpha_d = alpha_q;
    x1_d = x1_q;
    x2_d = x2_q;
    y1_d = y1_q;
    y2_d = y2_q;
    minref_d = minref_q;
    hold_d = hold_q;
    if (addr_ok && !hwrite) begin
      // Read data is latched in the address phase
      rdata_d = 32'h0;
      case (wr_addr_d)
        `REG_CTRL: rdata_d = {23'h0, therm_sel_q, 2'h0, mon_mode_q, 1'b0, in_mode_q};
        `REG_TOL: rdata_d = {20'h0, tol_q};
        `REG_TAU: rdata_d = {19'h0, tau_q};
        `REG_X1: rdata_d = {18'h0, x1_q};
        `REG_Y1: rdata_d = 32'(y1_q);
        `REG_X2: rdata_d = {18'h0, x2_q};
        `REG_Y2: rdata_d = 32'(y2_q);
        `REG_MINREF: rdata_d = {18'h0, minref_q};
        `REG_HOLD: rdata_d = {16'h0, hold_q};
        `REG_STATUS: rdata_d = {24'h0, 3'(mon_q), thermal_contact, digital_processed, error_out,
          fault_out, warn_out};
        `REG_FILT: rdata_d = {18'h0, fbus.y};
        `REG_REF: rdata_d = 32'(ref_out);
        default: rdata_d = 32'h0; // Unmapped reads as zero
      endcase
    end
    if (wr_pend_q) begin
      case (wr_addr_q)
        `REG_CTRL: begin
          in_mode_d = hwdata[`CTRL_INMODE];
          mon_mode_d = hwdata[`CTRL_MON];
          therm_sel_d = hwdata[`CTRL_THERM];
        end
        `REG_TOL: tol_d = hwdata > 32'(`TOL_MAX) ? `TOL_MAX : hwdata[11:0];
        `REG_TAU: begin
          // Only the fifteen listed codes are taken
          for (int i = 0; i < 15; i++) begin
            if (hwdata[12:0] == TAU_CODES[i] && hwdata[31:13] == 19'h0) begin
              tau_d = TAU_CODES[i];
              alpha_d = i == 0 ? `ALPHA_FULL : `ALPHA(TAU_CODES[i]);
            end
          end
        end
        `REG_X1: x1_d = hwdata[13:0];
        `REG_Y1: y1_d = hwdata[15:0];
        `REG_X2: x2_d = hwdata[13:0];
        `REG_Y2: y2_d = hwdata[15:0];
        `REG_MINREF: minref_d = hwdata[13:0];
        `REG_HOLD: hold_d = hwdata[15:0];
        default: ; // Status acknowledges and unmapped writes
      endcase
    end
  end

  // Register state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      rdata_q <= 32'h0;
      in_mode_q <= `INMODE_NPN;
      mon_mode_q <= `MON_OFF;
      therm_sel_q <= 1'b0;
      tol_q <= `TOL_RESET;
      tau_q <= `TAU_RESET;
      alpha_q <= `ALPHA_FULL;
      x1_q <= `X1_RESET;
      x2_q <= `X2_RESET;
      y1_q <= `Y1_RESET;
      y2_q <= `Y2_RESET;
      minref_q <= `MINREF_RESET;
      hold_q <= `HOLD_RESET;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      in_mode_q <= in_mode_d;
      mon_mode_q <= mon_mode_d;
      therm_sel_q <= therm_sel_d;
      tol_q <= tol_d;
      tau_q <= tau_d;
      alpha_q <= alpha_d;
      x1_q <= x1_d;
      x2_q <= x2_d;
      y1_q <= y1_d;
      y2_q <= y2_d;
      minref_q <= minref_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // Filter
  assign fbus.tick = sample_tick;
  assign fbus.x = analog_input_signal;
  assign fbus.alpha = alpha_q;

  lowpass_filter u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .f(fbus.filt)
  );

  ////////////////////////////////////////////////////////////
  // Characteristic with tolerance band
  logic signed [33:0] fs, dx, dy, raw, xz, tol_s, min_s, val; // Curve arithmetic
  logic sign_change, neg_slope, upper, lower, pos_side; // Band decode
  logic dir_q, dir_d; // Last side, 1 is positive
  logic signed [15:0] ref_q, ref_d; // Reference output

  // Curve, zero crossing and hysteresis
  always_comb begin
    fs = $signed({20'h0, fbus.y});
    dx = $signed({20'h0, x2_q}) - $signed({20'h0, x1_q});
    dy = 34'(y2_q) - 34'(y1_q);
    tol_s = $signed({22'h0, tol_q});
    min_s = $signed({20'h0, minref_q});
    raw = dx == 34'sh0 ? 34'(y1_q) : 34'(y1_q) + dy * (fs - $signed({20'h0, x1_q})) / dx;
    if (raw > `REF_LIMIT) raw = `REF_LIMIT;
    if (raw < -`REF_LIMIT) raw = -`REF_LIMIT;
    sign_change = (y1_q < 0 && y2_q > 0) || (y1_q > 0 && y2_q < 0);
    neg_slope = (dy < 0) ^ (dx < 0);
    xz = dy == 34'sh0 ? 34'sh0 : $signed({20'h0, x1_q}) - 34'(y1_q) * dx / dy;
    upper = fs > xz + tol_s;
    lower = fs < xz - tol_s;
    pos_side = upper ? !neg_slope : neg_slope;
    dir_d = (sign_change && (upper || lower)) ? pos_side : dir_q;
    val = raw;
    if (sign_change) begin
      if (!upper && !lower) begin
        val = dir_q ? min_s : -min_s;
      end else if (pos_side) begin
        val = raw < min_s ? min_s : raw;
      end else begin
        val = raw > -min_s ? -min_s : raw;
      end
    end
    ref_d = 16'(val);
  end

  // Characteristic registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dir_q <= 1'b1;
      ref_q <= 16'sh0;
    end else begin
      dir_q <= dir_d;
      ref_q <= ref_d;
    end
  end
  assign ref_out = ref_q;

  ////////////////////////////////////////////////////////////
  // Floor supervision
  localparam int unsigned CW = $clog2(CYCLES_PER_MS + 1); // Cycle counter width
  logic warn_q, warn_d, fault_q, fault_d, err_q, err_d; // Sticky flags
  logic start_q, seen_q, seen_d; // Start history
  logic [CW-1:0] cyc_q, cyc_d; // Cycles within one ms
  logic [15:0] ms_q, ms_d; // Elapsed ms of holding
  logic below, restart, ms_done; // Events

  assign below = (in_mode_q == `INMODE_VOLT || in_mode_q == `INMODE_CURR) && fbus.y < `FLOOR_LEVEL;
  assign restart = mon_q != MON_RUN && seen_q && start_q && !start_signal;
  assign ms_done = ms_q >= hold_q;

  // Next supervision state; a new event wins over any clear
  always_comb begin
    mon_d = mon_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    seen_d = mon_q != MON_RUN && (seen_q || (start_signal && !start_q));
    warn_d = (warn_q && !clr_warn && !restart) || (mon_mode_q != `MON_OFF && below);
    fault_d = (fault_q && !clr_fault && !restart) || (mon_mode_q[1] && below);
    err_d = err_q && !clr_error && !restart;
    unique case (mon_q)
      MON_RUN: begin
        if (mon_mode_q == `MON_RAMP && below) mon_d = MON_STOPPING;
        if (mon_mode_q == `MON_COAST && below) mon_d = MON_COASTING;
      end
      MON_STOPPING: begin
        if (drive_standstill) begin
          mon_d = MON_HOLDING;
          cyc_d = '0;
          ms_d = 16'h0;
        end
      end
      MON_HOLDING: begin
        // Count whole ms of holding time
        if (ms_done) begin
          mon_d = MON_ERROR;
          err_d = 1'b1;
        end else if (cyc_q == CW'(CYCLES_PER_MS - 1)) begin
          cyc_d = '0;
          ms_d = ms_q + 16'h1;
        end else begin
          cyc_d = cyc_q + 1'b1;
        end
      end
      MON_ERROR, MON_COASTING: ; // Wait for restart
    endcase
    if (restart) begin
      mon_d = MON_RUN;
      if (mon_mode_q == `MON_RAMP && below) mon_d = MON_STOPPING;
      if (mon_mode_q == `MON_COAST && below) mon_d = MON_COASTING;
    end
  end

  // Supervision registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mon_q <= MON_RUN;
      warn_q <= 1'b0;
      fault_q <= 1'b0;
      err_q <= 1'b0;
      start_q <= 1'b0;
      seen_q <= 1'b0;
      cyc_q <= '0;
      ms_q <= 16'h0;
    end else begin
      mon_q <= mon_d;
      warn_q <= warn_d;
      fault_q <= fault_d;
      err_q <= err_d;
      start_q <= start_signal;
      seen_q <= seen_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
    end
  end
  assign warn_out = warn_q;
  assign fault_out = fault_q;
  assign error_out = err_q;
  assign ramp_stop_req = mon_q == MON_STOPPING || mon_q == MON_HOLDING || mon_q == MON_ERROR;
  assign coast_req = mon_q == MON_COASTING;

  ////////////////////////////////////////////////////////////
  // Digital evaluation
  logic raw_q, raw_d, proc_q, proc_d, therm_q, therm_d; // Evaluated input stages

  // Polarity and source selection
  always_comb begin
    raw_d = in_mode_q == `INMODE_PNP ? digital_input_signal : !digital_input_signal;
    proc_d = raw_q && (in_mode_q == `INMODE_PNP || in_mode_q == `INMODE_NPN);
    therm_d = therm_sel_q ? proc_q : raw_q;
  end

  // Digital registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      raw_q <= 1'b0;
      proc_q <= 1'b0;
      therm_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      proc_q <= proc_d;
      therm_q <= therm_d;
    end
  end
  assign digital_raw = raw_q;
  assign digital_processed = proc_q;
  assign thermal_contact = therm_q;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_tol_range: assert property (tol_q <= `TOL_MAX)
    else $error("tolerance band above limit");
  chk_mode_off: assert property (mon_mode_q == `MON_OFF && !warn_q |=> !warn_q)
    else $error("warning raised with monitoring off");
  chk_warn_only: assert property (mon_mode_q == `MON_WARN && below && mon_q == MON_RUN
    |=> warn_q && mon_q == MON_RUN && !coast_req && !ramp_stop_req)
    else $error("warning mode misbehaved");
  chk_ramp_stop: assert property (mon_mode_q == `MON_RAMP && below && mon_q == MON_RUN
    |=> fault_q && warn_q && ramp_stop_req && !coast_req)
    else $error("controlled stop not requested");
  chk_coast_stop: assert property (mon_mode_q == `MON_COAST && below && mon_q == MON_RUN
    |=> fault_q && warn_q && coast_req && !ramp_stop_req)
    else $error("coasting not requested");
  chk_hold_error: assert property (mon_q == MON_HOLDING && ms_done && !restart
    |=> mon_q == MON_ERROR && err_q)
    else $error("error not issued after holding time");
  chk_restart_clear: assert property (restart && !below && !(mon_q == MON_HOLDING && ms_done)
    |=> mon_q == MON_RUN && !err_q)
    else $error("restart did not clear shutdown");
  chk_band_hold: assert property (sign_change && !upper && !lower
    |=> ref_q == (($past(dir_q)) ? 16'(minref_q) : -16'(minref_q)))
    else $error("band output not held at minimum");
  chk_polarity: assert property (##1 raw_q ==
    ($past(in_mode_q) == `INMODE_PNP ? $past(digital_input_signal) : !$past(digital_input_signal)))
    else $error("digital polarity wrong");
  chk_thermal_src: assert property (!therm_sel_q |=> thermal_contact == $past(raw_q))
    else $error("thermal contact not from raw source");
endmodule
`default_nettype wire

/* File: verilog/filt_if.sv */
// Purpose: Carries samples and coefficient between top and filter.
// Assumes: One clock domain.
// Notes: The filter answers with a registered average.
`timescale 1ns/100ps
`default_nettype none
interface filt_if;
  logic tick; // Sample strobe
  logic [13:0] x; // Raw sample
  logic [16:0] alpha; // Coefficient, 1.16 fixed point
  logic [13:0] y; // Filtered value
  modport ctrl (output tick, output x, output alpha, input y);
  modport filt (input tick, input x, input alpha, output y);
endinterface
`default_nettype wire

/* File: verilog/lowpass_filter.sv */
// Purpose: First-order recursive low-pass of the analog samples.
// Assumes: Coefficient equals sample period over time constant.
// Notes: Full coefficient copies the sample straight through.
`include "aic_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lowpass_filter
  import aic_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic reset, // Asynchronous reset
  filt_if.filt f // Sample in, average out
);
  logic [29:0] acc_q; // Average, 14.16 fixed point
  logic [29:0] acc_d; // Next average
  logic signed [30:0] diff; // Sample minus average
  logic signed [48:0] prod; // Scaled difference

  ////////////////////////////////////////////////////////////
  // Next average
  always_comb begin
    diff = $signed({1'b0, f.x, 16'h0000}) - $signed({1'b0, acc_q});
    prod = diff * $signed({1'b0, f.alpha});
    acc_d = acc_q;
    if (f.tick) begin
      if (f.alpha == `ALPHA_FULL) begin
        acc_d = {f.x, 16'h0000};
      end else begin
        acc_d = acc_q + prod[45:16];
      end
    end
  end

  // Average register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_q <= 30'h0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign f.y = acc_q[29:16];

  // Unfiltered setting copies the sample on the tick
  chk_pass_through: assert property (@(posedge ref_clk) disable iff (reset)
    f.tick && f.alpha == `ALPHA_FULL |=> f.y == $past(f.x))
    else $error("unfiltered sample not passed");
  // Averaging never falls on a tick while the sample is at or above the average
  chk_average_moves: assert property (@(posedge ref_clk) disable iff (reset)
    f.tick && f.alpha != `ALPHA_FULL && f.x >= f.y |=> f.y >= $past(f.y))
    else $error("average moved away from sample");
endmodule
`default_nettype wire
